// [irqpf_top.sv]
// Interrupt request pin front end: one non-maskable and four maskable lines.
// Assumes a processor core that raises instr_boundary between instructions
// and pulses irq_ack when it takes a maskable interrupt.
//
// Summary of operation
// - The non-maskable input is edge triggered and served as type 2.
// - Nothing software writes can block the non-maskable request.
// - A rising non-maskable edge is served at the next instruction boundary.
// - A caught non-maskable edge is held in a latch until served.
// - A non-maskable pulse of one clock or longer is always recognised.
// - The non-maskable input is synchronised before edge detection.
// - A high level or rising edge on a request line is a request.
// - Every maskable request input is synchronised before use.
// - Lines two and three can be turned irq_line0 active-low acknowledge outputs.
// - Each maskable line is set by software to edge or level triggering.
// - In slave mode the request pins leave their normal request roles.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module irqpf_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [15:0] bus_rdata,
   input wire logic nmi_in,
   input wire logic irq_line0,
   input wire logic irq_line1,
   input wire logic irq_line2,
   input wire logic irq_line3,
   output logic irq_ack_out0,
   output logic irq_ack_out0_oe,
   output logic irq_ack_out1,
   output logic irq_ack_out1_oe,
   input wire logic instr_boundary,
   input wire logic irq_ack,
   input wire logic [1:0] irq_ack_line,
   output logic nmi_take,
   output logic [7:0] nmi_type,
   output logic [3:0] irq_request,
   output logic [3:0] slave_lines,
   output logic irq_out
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      irqpf_pkg::irqpf_nmi_state_t nmi_st;
      logic nmi_latch;
      logic [3:0] trig_edge;
      logic [1:0] ack_en;
      logic slave;
      logic [3:0] edge_pend;
      logic [4:0] status;
      logic [4:0] mask;
      logic [15:0] rdata;
      logic nmi_take;
      logic [3:0] irq_req;
      logic [3:0] slave_lines;
      logic ack0;
      logic ack0_oe;
      logic ack1;
      logic ack1_oe;
      logic irq;
   } irqpf_state_t;

   irqpf_state_t st_q;
   irqpf_state_t st_d;
   irqpf_pkg::irqpf_bus_req_t req;

   logic nmi_level;
   logic nmi_rise;
   logic [3:0] line_raw;
   logic [3:0] line_level;
   logic [3:0] line_rise;

   assign req.addr = bus_addr;
   assign req.wdata = bus_wdata;
   assign req.wr = bus_wr;
   assign req.rd = bus_rd;
   assign line_raw = {irq_line3, irq_line2, irq_line1, irq_line0};

   // ------------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------------
   irqpf_sync u_nmi_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(nmi_in),
      .level_out(nmi_level),
      .rise_out(nmi_rise)
   );

   genvar gi;
   generate
      for (gi = 0; gi < irqpf_pkg::NUM_LINES; gi++) begin : g_line
         irqpf_sync u_line_sync (
            .clk_sys(clk_sys),
            .reset(reset),
            .async_in(line_raw[gi]),
            .level_out(line_level[gi]),
            .rise_out(line_rise[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [3:0] is_input;
      logic [3:0] active;
      logic [3:0] ack_hit;
      logic [4:0] ev;
      logic [4:0] clr;
      is_input = 4'h0;
      active = 4'h0;
      ack_hit = 4'h0;
      ev = 5'h00;
      clr = 5'h00;
      st_d = st_q;
      st_d.rdata = 16'h0000;
      st_d.nmi_take = 1'b0;

      // Lines two and three act as inputs unless turned irq_line0 ack outputs.
      is_input = {~st_q.ack_en[1], ~st_q.ack_en[0], 2'b11};
      if (st_q.slave) begin
         is_input = 4'h0;
      end

      // Acknowledge of a maskable line drops its pending edge.
      if (irq_ack) begin
         ack_hit[irq_ack_line] = 1'b1;
      end

      // Set wins over clear so an edge in the ack cycle survives.
      st_d.edge_pend = (st_q.edge_pend & ~ack_hit)
         | (line_rise & is_input);
      for (int i = 0; i < 4; i++) begin
         if (st_q.trig_edge[i]) begin
            active[i] = st_q.edge_pend[i] & is_input[i];
         end else begin
            // Level lines rely on the requester holding until acked.
            active[i] = line_level[i] & is_input[i];
         end
      end
      st_d.irq_req = active;
      st_d.slave_lines = st_q.slave ? line_level : 4'h0;

      // Non-maskable path: no mask bit is consulted anywhere here.
      case (st_q.nmi_st)
         irqpf_pkg::IRQPF_IDLE: begin
            if (nmi_rise) begin
               st_d.nmi_latch = 1'b1;
               st_d.nmi_st = irqpf_pkg::IRQPF_WAIT_BOUNDARY;
            end
         end
         irqpf_pkg::IRQPF_WAIT_BOUNDARY: begin
            if (instr_boundary) begin
               st_d.nmi_st = irqpf_pkg::IRQPF_SERVE;
               st_d.nmi_take = 1'b1;
            end
         end
         irqpf_pkg::IRQPF_SERVE: begin
            // A new edge during service stays pending for the next round.
            st_d.nmi_latch = nmi_rise;
            st_d.nmi_st = nmi_rise ? irqpf_pkg::IRQPF_WAIT_BOUNDARY
                                   : irqpf_pkg::IRQPF_IDLE;
         end
         default: begin
            st_d.nmi_st = irqpf_pkg::IRQPF_IDLE;
         end
      endcase

      // Acknowledge outputs are driven low for one cycle per ack.
      st_d.ack0_oe = st_q.ack_en[0] & ~st_q.slave;
      st_d.ack1_oe = st_q.ack_en[1] & ~st_q.slave;
      st_d.ack0 = ~(irq_ack & st_d.ack0_oe);
      st_d.ack1 = ~(irq_ack & st_d.ack1_oe);

      // Sticky status: events of the four lines and the NMI.
      ev = {nmi_rise, line_rise & is_input};
      if (req.wr && req.addr == irqpf_pkg::ADDR_TRIG) begin
         st_d.trig_edge = req.wdata[3:0];
      end else if (req.wr && req.addr == irqpf_pkg::ADDR_ACKEN) begin
         st_d.ack_en = req.wdata[1:0];
      end else if (req.wr && req.addr == irqpf_pkg::ADDR_STATUS) begin
         clr = req.wdata[4:0];
      end else if (req.wr && req.addr == irqpf_pkg::ADDR_MASK) begin
         st_d.mask = req.wdata[4:0];
      end else if (req.wr && req.addr == irqpf_pkg::ADDR_MODE) begin
         st_d.slave = req.wdata[0];
      end
      st_d.status = (st_q.status & ~clr) | ev;
      st_d.irq = |(st_d.status & st_d.mask);

      if (req.rd && req.addr == irqpf_pkg::ADDR_TRIG) begin
         st_d.rdata = {12'h000, st_q.trig_edge};
      end else if (req.rd && req.addr == irqpf_pkg::ADDR_ACKEN) begin
         st_d.rdata = {14'h0000, st_q.ack_en};
      end else if (req.rd && req.addr == irqpf_pkg::ADDR_STATUS) begin
         st_d.rdata = {11'h000, st_q.status};
      end else if (req.rd && req.addr == irqpf_pkg::ADDR_MASK) begin
         st_d.rdata = {11'h000, st_q.mask};
      end else if (req.rd && req.addr == irqpf_pkg::ADDR_MODE) begin
         st_d.rdata = {15'h0000, st_q.slave};
      end else if (req.rd && req.addr == irqpf_pkg::ADDR_PEND) begin
         st_d.rdata = {7'h00, st_q.nmi_latch, st_q.irq_req, line_level};
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= '0;
         st_q.nmi_st <= irqpf_pkg::IRQPF_IDLE;
         st_q.trig_edge <= irqpf_pkg::RST_TRIG;
         st_q.ack_en <= irqpf_pkg::RST_ACKEN;
         st_q.mask <= irqpf_pkg::RST_MASK;
         st_q.ack0 <= 1'b1;
         st_q.ack1 <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign bus_rdata = st_q.rdata;
   assign nmi_take = st_q.nmi_take;
   assign nmi_type = irqpf_pkg::NMI_TYPE;
   assign irq_request = st_q.irq_req;
   assign slave_lines = st_q.slave_lines;
   assign irq_ack_out0 = st_q.ack0;
   assign irq_ack_out0_oe = st_q.ack0_oe;
   assign irq_ack_out1 = st_q.ack1;
   assign irq_ack_out1_oe = st_q.ack1_oe;
   assign irq_out = st_q.irq;
endmodule // irqpf_top

// [irqpf_pkg.sv]
// Package of the interrupt request pin front end.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package irqpf_pkg;

   // ------------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned NMI_MIN_NS = 20;
   localparam int unsigned NMI_MIN_CYC =
      ((NMI_MIN_NS * (CLK_HZ / 1000000)) + 999) / 1000;
   localparam logic [7:0] NMI_TYPE = 8'h02;
   localparam int unsigned NUM_LINES = 4;
   localparam int unsigned FIRST_ACK_LINE = 2;

   localparam logic [3:0] ADDR_TRIG = 4'h0;
   localparam logic [3:0] ADDR_ACKEN = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_MASK = 4'h3;
   localparam logic [3:0] ADDR_MODE = 4'h4;
   localparam logic [3:0] ADDR_PEND = 4'h5;

   localparam logic [3:0] RST_TRIG = 4'h0;
   localparam logic [1:0] RST_ACKEN = 2'h0;
   localparam logic [4:0] RST_MASK = 5'h00;
   localparam int unsigned ST_NMI_BIT = 4;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      IRQPF_IDLE = 2'b00,
      IRQPF_WAIT_BOUNDARY = 2'b01,
      IRQPF_SERVE = 2'b10
   } irqpf_nmi_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } irqpf_bus_req_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } irqpf_sync_state_t;

endpackage : irqpf_pkg

// [irqpf_sync.sv]
// Two-flop synchroniser with rising edge detect on the synchronised copy.
// Assumes the input may change at any time relative to clk_sys.
`timescale 1ns/10ps
module irqpf_sync (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic async_in,
   output logic level_out,
   output logic rise_out
);
   irqpf_pkg::irqpf_sync_state_t st_q;
   irqpf_pkg::irqpf_sync_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
      st_d.prev = st_q.s2;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.s2;
   // Current synchronised sample against the previous one.
   assign rise_out = st_q.s2 & ~st_q.prev;
endmodule // irqpf_sync

// [irqpf_src_model.sv]
// Far-side model: four maskable requesters and one non-maskable source.
// Assumes raise, drop and fire commands change just after clk_sys edges.
`timescale 1ns/10ps
module irqpf_src_model (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] raise,
   input wire logic [3:0] drop,
   input wire logic nmi_fire,
   input wire logic irq_ack,
   input wire logic [1:0] irq_ack_line,
   output logic [3:0] line_q,
   output logic nmi_q
);
   logic [3:0] ack_v;
   assign ack_v = {3'h0, irq_ack} << irq_ack_line;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         line_q <= 4'h0;
         nmi_q <= 1'b0;
      end else begin
         // Drop is the only way to let go early, for the faulty requester.
         line_q <= (line_q | raise) & ~drop & ~ack_v;
         nmi_q <= nmi_fire;
      end
   end
endmodule // irqpf_src_model

// [irqpf_monitor.sv]
// Checker of the interrupt pin front end, bound to irqpf_top.
// Assumes the register offsets of irqpf_pkg.
`timescale 1ns/10ps
module irqpf_monitor (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic nmi_in,
   input wire logic irq_line0,
   input wire logic instr_boundary,
   input wire logic irq_ack,
   input wire logic irq_ack_out0,
   input wire logic nmi_take,
   input wire logic [7:0] nmi_type,
   input wire logic [3:0] irq_request
);
   logic trig0_q;
   logic acken0_q;
   logic slave_q;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trig0_q <= 1'b0;
         acken0_q <= 1'b0;
         slave_q <= 1'b0;
      end else if (bus_wr) begin
         if (bus_addr == irqpf_pkg::ADDR_TRIG) trig0_q <= bus_wdata[0];
         if (bus_addr == irqpf_pkg::ADDR_ACKEN) acken0_q <= bus_wdata[0];
         if (bus_addr == irqpf_pkg::ADDR_MODE) slave_q <= bus_wdata[0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   nmi_type_a:
      assert property (nmi_type == irqpf_pkg::NMI_TYPE) else $error("bad type");
   take_pulse_a:
      assert property (nmi_take |=> !nmi_take) else $error("take too long");
   take_boundary_a:
      assert property (nmi_take |-> $past(instr_boundary))
      else $error("take off boundary");
   nmi_served_a:
      assert property ($rose(nmi_in) |-> ##[1:6] (nmi_take || !instr_boundary))
      else $error("nmi not served");
   level_rise_a:
      assert property (!slave_q && !trig0_q && $rose(irq_line0) ##1
         irq_line0 [*3] |-> ##[0:1] irq_request[0]) else $error("no request");
   slave_quiet_a:
      assert property (slave_q && $past(slave_q, 3) |-> irq_request == 4'h0)
      else $error("request in slave mode");
   // Slave mode takes the pins away, so the ack is only owed outside it.
   ack_low_a:
      assert property (irq_ack && acken0_q && !slave_q && $past(acken0_q, 2)
         |=> !irq_ack_out0) else $error("no ack out");
   ack_cause_a:
      assert property (!irq_ack_out0 |-> $past(irq_ack))
      else $error("stray ack out");
   cover property (nmi_take);
   cover property ($rose(irq_request[0]));
   cover property (!irq_ack_out0);
endmodule // irqpf_monitor
bind irqpf_top irqpf_monitor irqpf_monitor_i (.clk_sys, .reset, .bus_addr,
   .bus_wdata, .bus_wr, .nmi_in, .irq_line0, .instr_boundary, .irq_ack,
   .irq_ack_out0, .nmi_take, .nmi_type, .irq_request);

// [irqpf_tb.sv]
// Testbench of the interrupt pin front end with its requester model.
// Assumes the register map and latencies of irqpf_pkg and the hand-over.
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] bus_addr = 4'h0;
   logic [15:0] bus_wdata = 16'h0000;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic instr_boundary = 1'b1;
   logic irq_ack = 1'b0;
   logic [1:0] irq_ack_line = 2'h0;
   logic [3:0] raise = 4'h0;
   logic [3:0] drop = 4'h0;
   logic nmi_fire = 1'b0;
   logic [15:0] bus_rdata;
   logic [3:0] src, irq_request, slave_lines;
   logic nmi_src, a0, a0_oe, a1, a1_oe, nmi_take, irq_out, l2, l3;
   logic [7:0] nmi_type;
   int miscompares = 0;
   int tests_run = 0;
   int takes = 0;
   // The shared pins carry the acknowledge whenever the device drives them.
   assign l2 = a0_oe ? a0 : src[2];
   assign l3 = a1_oe ? a1 : src[3];
   irqpf_src_model irqpf_src_model_i (.clk_sys, .reset, .raise, .drop,
      .nmi_fire, .irq_ack, .irq_ack_line, .line_q(src), .nmi_q(nmi_src));
   irqpf_top irqpf_top_i (.clk_sys, .reset, .bus_addr, .bus_wdata, .bus_wr,
      .bus_rd, .bus_rdata, .nmi_in(nmi_src), .irq_line0(src[0]),
      .irq_line1(src[1]), .irq_line2(l2), .irq_line3(l3), .irq_ack_out0(a0),
      .irq_ack_out0_oe(a0_oe), .irq_ack_out1(a1), .irq_ack_out1_oe(a1_oe),
      .instr_boundary, .irq_ack, .irq_ack_line, .nmi_take, .nmi_type,
      .irq_request, .slave_lines, .irq_out);
   initial forever #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (nmi_take === 1'b1) takes++;
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t ns got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 cmp(bus_rdata, exp);
      @(posedge clk_sys);
   endtask
   task automatic ack(input logic [1:0] line);
      irq_ack_line <= line;
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wait_take();
      for (int n = 0; n < 20 && nmi_take !== 1'b1; n++) @(posedge clk_sys);
      cmp({15'h0, nmi_take}, 16'h0001);
      if (nmi_take !== 1'b1) report_and_stop();
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
      wr(4'hf, 16'hffff);
      rd(4'hf, 16'h0000);
      wr(irqpf_pkg::ADDR_TRIG, 16'hffff);
      rd(irqpf_pkg::ADDR_TRIG, 16'h000f);
      wr(irqpf_pkg::ADDR_TRIG, 16'h0000);
      $display("registers done");
      instr_boundary <= 1'b0;
      nmi_fire <= 1'b1;
      @(posedge clk_sys);
      nmi_fire <= 1'b0;
      repeat (10) @(posedge clk_sys);
      cmp(16'(takes), 16'h0000);
      rd(irqpf_pkg::ADDR_STATUS, 16'h0010);
      cmp({15'h0, irq_out}, 16'h0000);
      wr(irqpf_pkg::ADDR_MASK, 16'h0010);
      cmp({15'h0, irq_out}, 16'h0001);
      instr_boundary <= 1'b1;
      wait_take();
      cmp({8'h00, nmi_type}, 16'h0002);
      repeat (4) @(posedge clk_sys);
      cmp(16'(takes), 16'h0001);
      wr(irqpf_pkg::ADDR_STATUS, 16'h0010);
      rd(irqpf_pkg::ADDR_STATUS, 16'h0000);
      cmp({15'h0, irq_out}, 16'h0000);
      $display("nmi done");
      raise <= 4'h1;
      @(posedge clk_sys);
      raise <= 4'h0;
      repeat (5) @(posedge clk_sys);
      cmp({12'h0, irq_request}, 16'h0001);
      ack(2'h0);
      repeat (5) @(posedge clk_sys);
      cmp({12'h0, irq_request}, 16'h0000);
      wr(irqpf_pkg::ADDR_TRIG, 16'h0002);
      raise <= 4'h2;
      @(posedge clk_sys);
      raise <= 4'h0;
      drop <= 4'h2;
      @(posedge clk_sys);
      drop <= 4'h0;
      repeat (6) @(posedge clk_sys);
      cmp({12'h0, irq_request}, 16'h0002);
      ack(2'h1);
      repeat (2) @(posedge clk_sys);
      cmp({12'h0, irq_request}, 16'h0000);
      rd(irqpf_pkg::ADDR_STATUS, 16'h0003);
      $display("maskable done");
      wr(irqpf_pkg::ADDR_ACKEN, 16'h0001);
      raise <= 4'h4;
      @(posedge clk_sys);
      raise <= 4'h0;
      repeat (5) @(posedge clk_sys);
      cmp({12'h0, a1_oe, a1, a0_oe, irq_request[2]}, 16'h0006);
      irq_ack_line <= 2'h2;
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      @(posedge clk_sys);
      cmp({15'h0, a0}, 16'h0000);
      wr(irqpf_pkg::ADDR_ACKEN, 16'h0002);
      irq_ack_line <= 2'h3;
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      @(posedge clk_sys);
      cmp({12'h0, a1_oe, a1, a0_oe, a0}, 16'h0009);
      wr(irqpf_pkg::ADDR_ACKEN, 16'h0000);
      $display("acknowledge done");
      wr(irqpf_pkg::ADDR_MODE, 16'h0001);
      raise <= 4'h1;
      @(posedge clk_sys);
      raise <= 4'h0;
      repeat (5) @(posedge clk_sys);
      cmp({8'h0, irq_request, slave_lines}, 16'h0001);
      ack(2'h0);
      wr(irqpf_pkg::ADDR_MODE, 16'h0000);
      $display("slave done");
      report_and_stop();
   end
endmodule // testbench
